// ### src/nci_pkg.sv
package nci_pkg;

  typedef logic [31:0] nci_word_t;

  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [3:0] DWORD_BE = 4'hF;

  localparam nci_word_t CMD_RESET = 32'h00000000;
  localparam nci_word_t STAT_RESET = 32'h00260000;
  localparam nci_word_t STICKY_MASK = 32'h0F008FFF;

  // Command bit positions
  localparam int C_RESTART = 7;
  localparam int C_HALT_RX = 6;
  localparam int C_HALT_TX = 5;
  localparam int C_RELEASE = 4;
  localparam int C_RXQ = 3;
  localparam int C_TXQ = 2;
  localparam int C_START = 1;
  localparam int C_STOP = 0;

  // Status bit positions
  localparam int S_IND_HI = 23;
  localparam int S_IND_LO = 17;
  localparam int S_PEND = 16;
  localparam int S_GPIO2 = 15;
  localparam int S_FATAL = 12;
  localparam int S_UNDER = 8;
  localparam int S_TXQE = 7;
  localparam int S_RQE = 2;

  // Offset match within the 256 byte window
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

endpackage

// ### src/nci_acc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nci_acc_if;
  logic cmd_wr;
  logic stat_wr;
  logic any_rd;
  logic cmd_rd;
  logic stat_rd;
  logic [31:0] wdata;
  modport dec (output cmd_wr, output stat_wr, output any_rd, output cmd_rd,
               output stat_rd, output wdata);
  modport regs (input cmd_wr, input stat_wr, input any_rd, input cmd_rd,
                input stat_rd, input wdata);
endinterface
`default_nettype wire

// ### src/nci_acc_dec.sv
`timescale 1ns/1ps
`default_nettype none
module nci_acc_dec
  import nci_pkg::*;
(
  input wire logic io_cycle_i,
  input wire logic mem_cycle_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic io_space_en_i,
  input wire logic mem_space_en_i,
  input wire logic mem_map_en_i,
  input wire logic rom_decode_en_i,
  nci_acc_if.dec acc
);
  wire logic io_ok;
  wire logic mem_ok;
  wire logic dw_ok;
  wire logic sel;

  // Window enables and dword-only register hits (any_rd ignores be_i)
  assign io_ok = io_cycle_i & io_space_en_i;
  assign mem_ok = mem_cycle_i & mem_space_en_i & mem_map_en_i & ~rom_decode_en_i;
  assign dw_ok = (be_i == DWORD_BE);
  assign sel = (io_ok | mem_ok) & dw_ok;

  assign acc.cmd_wr = sel & wr_i & reg_hit(addr_i, CMD_OFF);
  assign acc.stat_wr = sel & wr_i & reg_hit(addr_i, STAT_OFF);
  assign acc.any_rd = rd_i & (io_ok | mem_ok);
  assign acc.cmd_rd = sel & rd_i & reg_hit(addr_i, CMD_OFF);
  assign acc.stat_rd = sel & rd_i & reg_hit(addr_i, STAT_OFF);
  assign acc.wdata = wdata_i;
endmodule // nci_acc_dec
`default_nettype wire

// ### src/nci_low_event.sv
`timescale 1ns/1ps
`default_nettype none
module nci_low_event (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic fall_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Two-stage synchroniser, then falling edge
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      fall_o <= s3_r & ~s2_r;
    end
  end
endmodule // nci_low_event
`default_nettype wire

// ### src/nci_regs.sv
`timescale 1ns/1ps
`default_nettype none
module nci_regs
  import nci_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic io_cycle_i,
  input wire logic mem_cycle_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic io_space_en_i,
  input wire logic mem_space_en_i,
  input wire logic mem_map_en_i,
  input wire logic rom_decode_en_i,
  input wire logic reg_test_mode_i,
  input wire logic parity_resp_en_i,
  input wire logic bus_master_i,
  input wire logic monitor_mode_i,
  input wire logic [14:0] int_mask_i,
  input wire logic target_abort_i,
  input wire logic master_abort_i,
  input wire logic addr_parity_err_i,
  input wire logic data_parity_err_i,
  input wire logic frame_status_valid_i,
  input wire logic copy_threshold_passed_i,
  input wire logic receive_buffer_empty_i,
  input wire logic transmit_copy_busy_i,
  input wire logic receive_copy_busy_i,
  input wire logic transmitter_quiet_i,
  input wire logic receiver_quiet_i,
  input wire logic gpio_two_pin_i,
  input wire logic copy_threshold_event_i,
  input wire logic early_arrival_event_i,
  input wire logic counter_near_full_i,
  input wire logic tx_underrun_i,
  input wire logic tx_desc_host_owned_i,
  input wire logic rx_desc_host_owned_i,
  input wire logic rx_desc_fetch_i,
  input wire logic transmit_chain_done_i,
  input wire logic tx_frame_end_i,
  input wire logic per_frame_interrupt_flag_i,
  input wire logic crc_error_i,
  input wire logic buffer_overflow_warning_i,
  input wire logic header_copy_done_i,
  input wire logic frame_copy_done_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic underrun_restart_o,
  output logic halt_receive_dma_o,
  output logic halt_transmit_dma_o,
  output logic release_receive_frame_o,
  output logic receive_descriptor_queued_o,
  output logic transmit_descriptor_queued_o,
  output logic receiver_online_o,
  output logic unmasked_event_pending_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  nci_acc_if acc ();
  wire logic gpio_two_low_event;

  nci_acc_dec u_dec (
    .io_cycle_i(io_cycle_i),
    .mem_cycle_i(mem_cycle_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .addr_i(addr_i),
    .be_i(be_i),
    .wdata_i(wdata_i),
    .io_space_en_i(io_space_en_i),
    .mem_space_en_i(mem_space_en_i),
    .mem_map_en_i(mem_map_en_i),
    .rom_decode_en_i(rom_decode_en_i),
    .acc(acc.dec)
  );

  nci_low_event u_gpio2 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(gpio_two_pin_i),
    .fall_o(gpio_two_low_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command register

  wire logic [31:0] wd;
  wire logic cw;
  wire logic zero_clr;
  wire logic rxq_set;
  wire logic txq_set;
  wire logic rel_set;
  wire logic rxq_clr;
  wire logic txq_clr;
  wire logic rel_clr;
  wire logic rxq_nxt;
  wire logic txq_nxt;
  wire logic rel_nxt;
  wire logic online_nxt;

  assign wd = acc.wdata;
  assign cw = acc.cmd_wr;
  assign zero_clr = cw & reg_test_mode_i;
  assign rxq_set = cw & wd[C_RXQ];
  assign txq_set = cw & wd[C_TXQ];
  assign rel_set = cw & wd[C_RELEASE];
  assign rxq_clr = rx_desc_host_owned_i | (cw & wd[C_HALT_RX]) | (zero_clr & ~wd[C_RXQ]);
  assign txq_clr = tx_desc_host_owned_i | (cw & wd[C_HALT_TX]) | (zero_clr & ~wd[C_TXQ]);
  assign rel_clr = rx_desc_fetch_i | (zero_clr & ~wd[C_RELEASE]);
  assign rxq_nxt = rxq_set | (receive_descriptor_queued_o & ~rxq_clr);
  assign txq_nxt = txq_set | (transmit_descriptor_queued_o & ~txq_clr);
  assign rel_nxt = rel_set | (release_receive_frame_o & ~rel_clr);
  assign online_nxt = (cw & wd[C_STOP]) ? 1'b0 :
                      (cw & wd[C_START]) ? 1'b1 : receiver_online_o;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      underrun_restart_o <= CMD_RESET[C_RESTART];
      halt_receive_dma_o <= CMD_RESET[C_HALT_RX];
      halt_transmit_dma_o <= CMD_RESET[C_HALT_TX];
      release_receive_frame_o <= CMD_RESET[C_RELEASE];
      receive_descriptor_queued_o <= CMD_RESET[C_RXQ];
      transmit_descriptor_queued_o <= CMD_RESET[C_TXQ];
      receiver_online_o <= 1'b0;
    end else begin
      underrun_restart_o <= cw & wd[C_RESTART];
      halt_receive_dma_o <= cw & wd[C_HALT_RX];
      halt_transmit_dma_o <= cw & wd[C_HALT_TX];
      release_receive_frame_o <= rel_nxt;
      receive_descriptor_queued_o <= rxq_nxt;
      transmit_descriptor_queued_o <= txq_nxt;
      receiver_online_o <= online_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status register

  nci_word_t stat_r;
  nci_word_t stat_nxt;
  nci_word_t ev_set;
  nci_word_t sw_clr;
  nci_word_t sw_set;
  nci_word_t auto_clr;
  logic [6:0] ind_r;
  wire logic fatal;
  wire logic [14:0] low_view;
  wire logic pend_nxt;

  assign ev_set = {4'h0,
                   target_abort_i,
                   master_abort_i,
                   addr_parity_err_i & ~bus_master_i & parity_resp_en_i,
                   data_parity_err_i & bus_master_i & parity_resp_en_i,
                   8'h00,
                   gpio_two_low_event,
                   3'b000,
                   copy_threshold_event_i,
                   early_arrival_event_i,
                   counter_near_full_i,
                   tx_underrun_i,
                   tx_desc_host_owned_i,
                   transmit_chain_done_i,
                   tx_frame_end_i & per_frame_interrupt_flag_i,
                   crc_error_i & ~monitor_mode_i,
                   buffer_overflow_warning_i,
                   rx_desc_host_owned_i,
                   header_copy_done_i,
                   frame_copy_done_i};
  // write one clears, test zero sets
  assign sw_clr = acc.stat_wr ? (wd & STICKY_MASK) : 32'h00000000;
  assign sw_set = (acc.stat_wr & reg_test_mode_i) ? (~wd & STICKY_MASK) : 32'h00000000;
  assign auto_clr = {23'h000000, cw & wd[C_RESTART], txq_set, 4'h0, rxq_set, 2'b00};
  assign stat_nxt = ((stat_r & ~(sw_clr | auto_clr)) | ev_set | sw_set) & STICKY_MASK;
  assign fatal = |stat_r[27:24];
  assign low_view = {2'b00, fatal, stat_r[11:0]};
  assign pend_nxt = |(low_view & int_mask_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_r <= STAT_RESET & STICKY_MASK;
      ind_r <= STAT_RESET[S_IND_HI:S_IND_LO];
      unmasked_event_pending_o <= STAT_RESET[S_PEND];
    end else begin
      stat_r <= stat_nxt;
      ind_r <= {frame_status_valid_i, copy_threshold_passed_i, receive_buffer_empty_i,
                transmit_copy_busy_i, receive_copy_busy_i, transmitter_quiet_i,
                receiver_quiet_i};
      unmasked_event_pending_o <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire nci_word_t cmd_view;
  wire nci_word_t stat_view;
  wire nci_word_t rd_mux;

  assign cmd_view = {24'h000000, 3'b000, release_receive_frame_o,
                     receive_descriptor_queued_o, transmit_descriptor_queued_o, 2'b00};
  assign stat_view = {stat_r[31:24], ind_r, unmasked_event_pending_o,
                      stat_r[15:13], fatal, stat_r[11:0]};
  assign rd_mux = acc.cmd_rd ? cmd_view :
                  acc.stat_rd ? stat_view : 32'h00000000;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h00000000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= acc.any_rd;
      if (acc.any_rd) begin
        rdata_o <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_restart_pulse: assert property (
    cw && wd[C_RESTART] |=> underrun_restart_o)
    else $error("restart pulse missing");
  a_restart_idle: assert property (
    !(cw && wd[C_RESTART]) |=> !underrun_restart_o)
    else $error("restart pulse without write");
  a_restart_clear: assert property (
    cw && wd[C_RESTART] && !tx_underrun_i |=> !stat_r[S_UNDER])
    else $error("underrun not cleared by restart");
  a_halt_rx: assert property (
    cw && wd[C_HALT_RX] && !wd[C_RXQ] |=> !receive_descriptor_queued_o && halt_receive_dma_o)
    else $error("receive halt wrong");
  a_halt_tx: assert property (
    cw && wd[C_HALT_TX] && !wd[C_TXQ] |=> !transmit_descriptor_queued_o && halt_transmit_dma_o)
    else $error("transmit halt wrong");
  a_release_fetch: assert property (
    rx_desc_fetch_i && !rel_set |=> !release_receive_frame_o)
    else $error("release not cleared");
  a_rx_queue: assert property (
    rxq_set && !rx_desc_host_owned_i |=> receive_descriptor_queued_o && !stat_r[S_RQE])
    else $error("receive queue wrong");
  a_tx_queue: assert property (
    txq_set && !tx_desc_host_owned_i |=> transmit_descriptor_queued_o && !stat_r[S_TXQE])
    else $error("transmit queue wrong");
  a_test_zero: assert property (
    zero_clr && !wd[C_TXQ] |=> !transmit_descriptor_queued_o)
    else $error("test zero write did not clear");
  a_rx_online: assert property (
    cw && wd[C_START] && !wd[C_STOP] |=> receiver_online_o)
    else $error("receiver not online");
  a_w1c_clear: assert property (
    acc.stat_wr && wd[0] && !frame_copy_done_i |=> !stat_r[0])
    else $error("write one did not clear");
  a_gpio_event: assert property (
    gpio_two_low_event |=> stat_r[S_GPIO2])
    else $error("pin event lost");
  a_fatal_read: assert property (
    acc.stat_rd |=> rdata_o[S_FATAL] == $past(fatal) && rvalid_o)
    else $error("fatal summary wrong");
  a_pending: assert property (
    ##1 unmasked_event_pending_o == $past(pend_nxt))
    else $error("pending flag wrong");

endmodule // nci_regs
`default_nettype wire

// ### test/nci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nci_host_model
  import nci_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic mem_sel_i,
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o,
  output logic io_cycle_i,
  output logic mem_cycle_i,
  output logic wr_i,
  output logic rd_i,
  output logic [7:0] addr_i,
  output logic [3:0] be_i,
  output logic [31:0] wdata_i
);
  initial begin
    {io_cycle_i, mem_cycle_i, wr_i, rd_i} = 4'h0;
    addr_i = 8'h00;
    be_i = DWORD_BE;
    wdata_i = 32'h00000000;
  end
  task automatic drive(input logic w, input logic [7:0] a, input nci_word_t d);
    @(negedge ref_clk_i);
    io_cycle_i = ~mem_sel_i;
    mem_cycle_i = mem_sel_i;
    addr_i = a;
    be_i = DWORD_BE;
    wdata_i = (a == CMD_OFF) ? {24'h000000, d[7:0]} : d;
    wr_i = w;
    rd_i = ~w;
    @(negedge ref_clk_i);
    {io_cycle_i, mem_cycle_i, wr_i, rd_i} = 4'h0;
    addr_i = ~a;
    wdata_i = ~wdata_i;
  endtask
  task automatic wr(input logic [7:0] a, input nci_word_t d);
    drive(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output nci_word_t d);
    drive(1'b0, a, 32'h00000000);
    d = rvalid_o ? rdata_o : 32'hXXXXXXXX;
  endtask
endmodule // nci_host_model
`default_nettype wire

// ### test/nic_command_and_interrupt_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module nic_command_and_interrupt_status_tb_top
  import nci_pkg::*;
;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, mem_sel_i = 1'b0, io_space_en_i = 1'b1;
  logic mem_space_en_i = 1'b0, mem_map_en_i = 1'b0, rom_decode_en_i = 1'b0;
  logic reg_test_mode_i = 1'b0, parity_resp_en_i = 1'b1, bus_master_i = 1'b0;
  logic monitor_mode_i = 1'b0, gpio_two_pin_i = 1'b1, rx_desc_fetch_i = 1'b0;
  logic per_frame_interrupt_flag_i = 1'b1;
  logic [14:0] int_mask_i = 15'h0000;
  logic [27:0] ev = 28'h0000000;
  logic [6:0] ind = 7'h13;
  wire target_abort_i, master_abort_i, addr_parity_err_i, data_parity_err_i;
  wire copy_threshold_event_i, early_arrival_event_i, counter_near_full_i, tx_underrun_i;
  wire tx_desc_host_owned_i, transmit_chain_done_i, tx_frame_end_i, crc_error_i;
  wire buffer_overflow_warning_i, rx_desc_host_owned_i, header_copy_done_i, frame_copy_done_i;
  wire frame_status_valid_i, copy_threshold_passed_i, receive_buffer_empty_i;
  wire transmit_copy_busy_i, receive_copy_busy_i, transmitter_quiet_i, receiver_quiet_i;
  wire io_cycle_i, mem_cycle_i, wr_i, rd_i, rvalid_o, underrun_restart_o, halt_receive_dma_o;
  wire halt_transmit_dma_o, release_receive_frame_o, receive_descriptor_queued_o;
  wire transmit_descriptor_queued_o, receiver_online_o, unmasked_event_pending_o;
  wire [7:0] addr_i;
  wire [3:0] be_i;
  wire [31:0] wdata_i, rdata_o;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  nci_word_t d;
  assign {target_abort_i, master_abort_i, addr_parity_err_i, data_parity_err_i} = ev[27:24];
  assign {copy_threshold_event_i, early_arrival_event_i, counter_near_full_i, tx_underrun_i,
    tx_desc_host_owned_i, transmit_chain_done_i, tx_frame_end_i, crc_error_i,
    buffer_overflow_warning_i, rx_desc_host_owned_i, header_copy_done_i,
    frame_copy_done_i} = ev[11:0];
  assign {frame_status_valid_i, copy_threshold_passed_i, receive_buffer_empty_i,
    transmit_copy_busy_i, receive_copy_busy_i, transmitter_quiet_i, receiver_quiet_i} = ind;
  nci_regs u_nci_regs (.*);
  nci_host_model u_nci_host_model (.*);
  always #12.5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////
  function automatic nci_word_t ix();
    return {8'h00, ind, 17'h00000};
  endfunction
  task automatic w(input logic [7:0] a, input nci_word_t v);
    u_nci_host_model.wr(a, v);
  endtask
  task automatic chk_rd(input logic [7:0] a, input nci_word_t e);
    u_nci_host_model.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic pulse(input int b);
    @(negedge ref_clk_i) ev[b] = 1'b1;
    @(negedge ref_clk_i) ev[b] = 1'b0;
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_rd(CMD_OFF, CMD_RESET);
    chk_rd(STAT_OFF, STAT_RESET);
    chk_rd(8'h08, 32'h00000000);
  endtask
  task automatic t_sticky();
    for (int b = 0; b < 28; b++) begin
      if (STICKY_MASK[b] && b != S_GPIO2) begin
        bus_master_i = (b == 24);
        pulse(b);
        chk_rd(STAT_OFF, ix() | (32'h1 << b) | ((b > 23) ? 32'h1000 : 32'h0));
        w(STAT_OFF, 32'h1 << b);
        chk_rd(STAT_OFF, ix());
      end
    end
    parity_resp_en_i = 1'b0;
    monitor_mode_i = 1'b1;
    per_frame_interrupt_flag_i = 1'b0;
    pulse(25);
    pulse(4);
    pulse(5);
    chk_rd(STAT_OFF, ix());
    parity_resp_en_i = 1'b1;
    monitor_mode_i = 1'b0;
    per_frame_interrupt_flag_i = 1'b1;
    bus_master_i = 1'b1;
    pulse(25);
    bus_master_i = 1'b0;
    pulse(24);
    chk_rd(STAT_OFF, ix());
  endtask
  task automatic t_cmd();
    pulse(8);
    w(CMD_OFF, 32'h80);
    `CHK(underrun_restart_o, 1'b1)
    chk_rd(STAT_OFF, ix());
    chk_rd(CMD_OFF, 32'h0);
    pulse(2);
    pulse(7);
    w(CMD_OFF, 32'h0C);
    chk_rd(STAT_OFF, ix());
    w(CMD_OFF, 32'h40);
    `CHK({halt_receive_dma_o, receive_descriptor_queued_o}, 2'b10)
    w(CMD_OFF, 32'h20);
    `CHK({halt_transmit_dma_o, transmit_descriptor_queued_o}, 2'b10)
    w(CMD_OFF, 32'h0C);
    pulse(7);
    `CHK(transmit_descriptor_queued_o, 1'b0)
    pulse(2);
    chk_rd(CMD_OFF, 32'h0);
    chk_rd(STAT_OFF, ix() | 32'h84);
    w(STAT_OFF, 32'h84);
    w(CMD_OFF, 32'h10);
    `CHK(release_receive_frame_o, 1'b1)
    @(negedge ref_clk_i) rx_desc_fetch_i = 1'b1;
    @(negedge ref_clk_i) rx_desc_fetch_i = 1'b0;
    `CHK(release_receive_frame_o, 1'b0)
  endtask
  task automatic t_test_mode();
    w(CMD_OFF, 32'h1C);
    w(CMD_OFF, 32'h0);
    chk_rd(CMD_OFF, 32'h1C);
    reg_test_mode_i = 1'b1;
    w(STAT_OFF, 32'hFFFFFF7F);
    reg_test_mode_i = 1'b0;
    w(STAT_OFF, 32'h80);
    chk_rd(CMD_OFF, 32'h1C);
    reg_test_mode_i = 1'b1;
    w(CMD_OFF, 32'h0);
    w(STAT_OFF, 32'h0);
    reg_test_mode_i = 1'b0;
    chk_rd(CMD_OFF, 32'h0);
    chk_rd(STAT_OFF, ix() | STICKY_MASK | 32'h1000);
    w(STAT_OFF, 32'hFFFFFFFF);
  endtask
  task automatic t_online();
    w(CMD_OFF, 32'h2);
    `CHK(receiver_online_o, 1'b1)
    w(CMD_OFF, 32'h0);
    `CHK(receiver_online_o, 1'b1)
    w(CMD_OFF, 32'h1);
    `CHK(receiver_online_o, 1'b0)
    w(CMD_OFF, 32'h0);
    `CHK(receiver_online_o, 1'b0)
  endtask
  task automatic t_misc();
    int_mask_i = 15'h0001;
    pulse(0);
    @(negedge ref_clk_i);
    `CHK(unmasked_event_pending_o, 1'b1)
    chk_rd(STAT_OFF, ix() | 32'h10001);
    w(STAT_OFF, 32'h1);
    @(negedge ref_clk_i);
    `CHK(unmasked_event_pending_o, 1'b0)
    int_mask_i = 15'h7FFF;
    ind = 7'h6C;
    repeat (2) @(negedge ref_clk_i);
    chk_rd(STAT_OFF, ix());
    gpio_two_pin_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk_rd(STAT_OFF, ix() | 32'h8000);
    w(STAT_OFF, 32'h8000);
    gpio_two_pin_i = 1'b1;
    mem_sel_i = 1'b1;
    mem_space_en_i = 1'b1;
    mem_map_en_i = 1'b1;
    chk_rd(STAT_OFF, ix());
    rom_decode_en_i = 1'b1;
    w(CMD_OFF, 32'h10);
    rom_decode_en_i = 1'b0;
    mem_sel_i = 1'b0;
    chk_rd(CMD_OFF, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_sticky();
    t_cmd();
    t_test_mode();
    t_online();
    t_misc();
    close_out();
  end
endmodule // nic_command_and_interrupt_status_tb_top
`default_nettype wire
